// ==== hdl/rx_status.sv ====
// Receive serializer status: error flags, slot counter, interrupt, registers.
// Assumes bit clock, frame sync and data pins are asynchronous to core_clk
// and that the clock check circuit pulses clk_fail_report on core_clk.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

// Functional notes
// [R1] Clock failure report sets status bit 2; stays set until cleared.
// [R2] Interrupt while clock failure flag and its enable are both set.
// [R3] Writing one clears an error flag; writing zero leaves it alone.
// [R4] Frame sync arriving before the frame ends sets status bit 1.
// [R5] Interrupt while early sync flag and its enable are both set.
// [R6] New word into a still unread buffer sets overrun, status bit 0.
// [R7] Interrupt while overrun flag and its enable are both set.
// [R8] Slot register bits 9..0 show the current slot, zero after reset.
// [R9] Slot count stays within 0 through 383.
// [R10] Ordinary time-division frames hold at most 32 slots.
// [R11] In block receive mode the slot counter runs past 32 to 383.
// [R12] Slot register upper bits read zero and ignore writes.
// [R13] Status bit 8 is the OR of all receive error flags.
// [R14] Status bit 3 mirrors the slot count's least significant bit.
// [R15] Slot count restarts at valid sync, advances each following slot.
module rx_status
	import rx_status_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        rx_bit_clk_pin,
	input  wire logic        rx_frame_sync_pin,
	input  wire logic        rx_data_pin,
	input  wire logic        clk_fail_report,
	output logic             rx_interrupt,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// Sticky flag: a set in the same cycle as a clear wins.
	function automatic logic sticky(input logic cur, input logic set,
		input logic clr);
		sticky = set || (cur && !clr);
	endfunction

	function automatic logic [SLOT_W-1:0] sat_min(
		input logic [SLOT_W-1:0] a, input logic [SLOT_W-1:0] b);
		sat_min = (a < b) ? a : b;
	endfunction

	logic        bclk_s;
	logic        fs_s;
	logic        data_s;
	logic        bclk_prev_reg;
	logic        fs_prev_reg;

	logic        wr_stb;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_hit;
	logic        rd_stb;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;
	logic        rd_hit;

	logic [FLAG_W-1:0] flags_reg;
	logic [FLAG_W-1:0] flags_next;
	logic [FLAG_W-1:0] int_en_reg;
	logic [4:0]        bits_m1_reg;
	logic [SLOT_W-1:0] slots_m1_reg;
	logic              dir_mode_reg;

	frame_e            state_reg;
	frame_e            state_next;
	logic [4:0]        bit_cnt_reg;
	logic [4:0]        bit_cnt_next;
	logic [SLOT_W-1:0] slot_reg;
	logic [SLOT_W-1:0] slot_next;
	logic [31:0]       shift_reg;
	logic [31:0]       shift_next;
	logic [31:0]       rx_buffer_reg;
	logic [31:0]       rx_buffer_next;
	logic              buf_full_reg;
	logic              buf_full_next;

	pin_sync u_sync_bclk (
		.core_clk (core_clk),
		.rst      (rst),
		.pin_in   (rx_bit_clk_pin),
		.pin_out  (bclk_s)
	);

	pin_sync u_sync_fs (
		.core_clk (core_clk),
		.rst      (rst),
		.pin_in   (rx_frame_sync_pin),
		.pin_out  (fs_s)
	);

	pin_sync u_sync_data (
		.core_clk (core_clk),
		.rst      (rst),
		.pin_in   (rx_data_pin),
		.pin_out  (data_s)
	);

	axil_slave u_bus (
		.core_clk      (core_clk),
		.rst           (rst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_stb        (wr_stb),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_hit        (wr_hit),
		.rd_stb        (rd_stb),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_hit        (rd_hit)
	);

	// Bit clock rising edge seen on the synchronised copy.
	wire bit_edge = bclk_s && !bclk_prev_reg;
	// Frame sync counts only at its leading edge, sampled on a bit edge.
	wire sync_evt = bit_edge && fs_s && !fs_prev_reg;

	// Ordinary time-division frames are clamped to 32 slots.
	wire [SLOT_W-1:0] tdm_last = sat_min(slots_m1_reg, TDM_MAX); // R10
	wire [SLOT_W-1:0] blk_last = sat_min(slots_m1_reg, SLOT_MAX); // R9
	wire [SLOT_W-1:0] last_slot = dir_mode_reg ? blk_last : tdm_last; // R11

	wire slot_end  = bit_cnt_reg == bits_m1_reg;
	wire frame_end = slot_end && (slot_reg == last_slot);
	wire in_frame  = state_reg == ST_FRAME;

	// A sync on the last bit edge of a frame steals that bit, so it is early too.
	wire early_sync = sync_evt && in_frame; // R4
	wire word_done  = bit_edge && (in_frame || sync_evt) &&
		(sync_evt ? (bits_m1_reg == 5'h00) : slot_end);

	wire wr_stat   = wr_stb && (wr_addr == ADDR_STAT) && wr_strb[0];
	wire wr_intctl = wr_stb && (wr_addr == ADDR_INTCTL);
	wire wr_fmt    = wr_stb && (wr_addr == ADDR_FMT);
	wire buf_read  = rd_stb && (rd_addr == ADDR_BUF);
	// Overrun: the read in the same cycle frees the buffer first.
	wire overrun   = word_done && buf_full_reg && !buf_read; // R6

	assign wr_hit = (wr_addr == ADDR_STAT) || (wr_addr == ADDR_INTCTL) ||
		(wr_addr == ADDR_FMT) || (wr_addr == ADDR_SLOT) ||
		(wr_addr == ADDR_BUF);
	assign rd_hit = (rd_addr == ADDR_STAT) || (rd_addr == ADDR_INTCTL) ||
		(rd_addr == ADDR_FMT) || (rd_addr == ADDR_SLOT) ||
		(rd_addr == ADDR_BUF);

	wire [CNT_W-1:0] slot_cnt = {1'b0, slot_reg}; // R8

	wire [31:0] stat_word = {23'h000000, |flags_reg, 4'h0, // R13
		slot_reg[0], flags_reg}; // R14
	wire [31:0] fmt_word = {7'h00, dir_mode_reg, 7'h00, slots_m1_reg,
		3'h0, bits_m1_reg};
	// Upper bits of the slot register read as zero.
	wire [31:0] slot_word = {22'h000000, slot_cnt}; // R12

	assign rd_data = (rd_addr == ADDR_STAT)   ? stat_word :
	                 (rd_addr == ADDR_INTCTL) ? {29'h0, int_en_reg} :
	                 (rd_addr == ADDR_FMT)    ? fmt_word :
	                 (rd_addr == ADDR_SLOT)   ? slot_word :
	                 (rd_addr == ADDR_BUF)    ? rx_buffer_reg :
	                 32'h00000000;

	// One-to-clear status bits; each event wins over a clear in its cycle.
	always_comb begin
		flags_next[BIT_CKF]  = sticky(flags_reg[BIT_CKF], clk_fail_report, // R1
			wr_stat && wr_data[BIT_CKF]); // R3
		flags_next[BIT_SYNC] = sticky(flags_reg[BIT_SYNC], early_sync,
			wr_stat && wr_data[BIT_SYNC]); // R3
		flags_next[BIT_OVRN] = sticky(flags_reg[BIT_OVRN], overrun,
			wr_stat && wr_data[BIT_OVRN]); // R3
	end

	// Frame tracking and serial shift.
	always_comb begin
		state_next     = state_reg;
		bit_cnt_next   = bit_cnt_reg;
		slot_next      = slot_reg;
		shift_next     = shift_reg;
		rx_buffer_next = rx_buffer_reg;
		buf_full_next  = buf_full_reg && !buf_read;
		if (bit_edge) begin
			case (state_reg)
				ST_IDLE, ST_WAIT: begin
					if (sync_evt) begin
						state_next   = ST_FRAME;
						bit_cnt_next = 5'h01;
						slot_next    = '0; // R15
						shift_next   = {31'h0, data_s};
					end
				end
				ST_FRAME: begin
					shift_next = {shift_reg[30:0], data_s};
					if (sync_evt) begin
						bit_cnt_next = 5'h01;
						slot_next    = '0; // R15
						shift_next   = {31'h0, data_s};
					end else if (frame_end) begin
						state_next   = ST_WAIT;
						bit_cnt_next = 5'h00;
					end else if (slot_end) begin
						bit_cnt_next = 5'h00;
						slot_next    = sat_min(slot_reg + 9'h001, SLOT_MAX); // R9 R15
					end else begin
						bit_cnt_next = bit_cnt_reg + 5'h01;
					end
				end
				default: begin
					state_next = ST_IDLE;
				end
			endcase
			// A one-bit slot wraps straight back to its first bit.
			if (sync_evt && bits_m1_reg == 5'h00) begin
				bit_cnt_next = 5'h00;
			end
		end
		if (word_done) begin
			rx_buffer_next = shift_next;
			buf_full_next  = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			bclk_prev_reg <= 1'b0;
			fs_prev_reg   <= 1'b0;
		end else begin
			bclk_prev_reg <= bclk_s;
			if (bit_edge) begin
				fs_prev_reg <= fs_s;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg     <= ST_IDLE;
			bit_cnt_reg   <= 5'h00;
			slot_reg      <= '0; // R8
			shift_reg     <= 32'h00000000;
			rx_buffer_reg <= 32'h00000000;
			buf_full_reg  <= 1'b0;
			flags_reg     <= '0;
		end else begin
			state_reg     <= state_next;
			bit_cnt_reg   <= bit_cnt_next;
			slot_reg      <= slot_next;
			shift_reg     <= shift_next;
			rx_buffer_reg <= rx_buffer_next;
			buf_full_reg  <= buf_full_next;
			flags_reg     <= flags_next;
		end
	end

	// Writable configuration; writes to the slot register change nothing.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			int_en_reg   <= '0;
			bits_m1_reg  <= BITS_RST;
			slots_m1_reg <= SLOTS_RST;
			dir_mode_reg <= 1'b0;
		end else begin
			if (wr_intctl && wr_strb[0]) begin
				int_en_reg <= wr_data[FLAG_W-1:0];
			end
			if (wr_fmt && wr_strb[0]) begin
				bits_m1_reg <= wr_data[FMT_BITS_HI:FMT_BITS_LO];
			end
			if (wr_fmt && wr_strb[1]) begin
				slots_m1_reg[7:0] <= wr_data[FMT_SLOTS_HI-1:FMT_SLOTS_LO];
			end
			if (wr_fmt && wr_strb[2]) begin
				slots_m1_reg[SLOT_W-1] <= wr_data[FMT_SLOTS_HI];
			end
			if (wr_fmt && wr_strb[3]) begin
				dir_mode_reg <= wr_data[FMT_DIR];
			end
		end
	end

	// Level interrupt: any flag whose enable is set.
	assign rx_interrupt = |(flags_reg & int_en_reg); // R2 R5 R7

endmodule // rx_status

// ==== pkg/rx_status_pkg.sv ====
// Constants for the receive error flag and slot counter block.
// Assumes a 32-bit AXI4-Lite register bus and one core clock.
package rx_status_pkg;

	localparam logic [7:0] ADDR_BUF    = 8'h74;
	localparam logic [7:0] ADDR_FMT    = 8'h78;
	localparam logic [7:0] ADDR_INTCTL = 8'h7C;
	localparam logic [7:0] ADDR_STAT   = 8'h80;
	localparam logic [7:0] ADDR_SLOT   = 8'h84;

	localparam int BIT_OVRN  = 0;
	localparam int BIT_SYNC  = 1;
	localparam int BIT_CKF   = 2;
	localparam int BIT_PAR   = 3;
	localparam int BIT_ERR   = 8;
	localparam int FLAG_W    = 3;

	localparam int FMT_BITS_LO  = 0;
	localparam int FMT_BITS_HI  = 4;
	localparam int FMT_SLOTS_LO = 8;
	localparam int FMT_SLOTS_HI = 16;
	localparam int FMT_DIR      = 24;

	localparam int SLOT_W = 9;
	localparam int CNT_W  = 10;
	localparam logic [SLOT_W-1:0] SLOT_MAX = 9'h17F;
	localparam logic [SLOT_W-1:0] TDM_MAX  = 9'h01F;
	localparam logic [4:0] BITS_RST  = 5'h1F;
	localparam logic [SLOT_W-1:0] SLOTS_RST = 9'h001;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_FRAME = 3'b010,
		ST_WAIT  = 3'b100
	} frame_e;

endpackage

// ==== hdl/pin_sync.sv ====
// Two-flop synchroniser for one pin input.
// Assumes the pin is asynchronous to core_clk.
`timescale 1ns/1ps
module pin_sync (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic pin_in,
	output logic      pin_out
);

	logic meta_reg;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_reg <= 1'b0;
			pin_out  <= 1'b0;
		end else begin
			meta_reg <= pin_in;
			pin_out  <= meta_reg;
		end
	end

endmodule // pin_sync

// ==== hdl/axil_slave.sv ====
// AXI4-Lite slave front end: turns bus traffic into write and read strobes.
// Assumes read data is presented combinationally by the owner of the registers.
`timescale 1ns/1ps
module axil_slave
	import rx_status_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             wr_stb,
	output logic [7:0]       wr_addr,
	output logic [31:0]      wr_data,
	output logic [3:0]       wr_strb,
	input  wire logic        wr_hit,
	output logic             rd_stb,
	output logic [7:0]       rd_addr,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_hit
);

	logic aw_have_reg;
	logic w_have_reg;

	// Address and data are latched independently so either may come first.
	assign s_axi_awready = !aw_have_reg;
	assign s_axi_wready  = !w_have_reg;
	assign wr_stb        = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_stb        = s_axi_arvalid && s_axi_arready;
	assign rd_addr       = s_axi_araddr;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			aw_have_reg  <= 1'b0;
			w_have_reg   <= 1'b0;
			wr_addr      <= 8'h00;
			wr_data      <= 32'h00000000;
			wr_strb      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				wr_addr     <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				wr_data    <= s_axi_wdata;
				wr_strb    <= s_axi_wstrb;
			end
			if (wr_stb) begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (rd_stb) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_data;
				s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // axil_slave

// ==== verif/rx_status_properties.sv ====
// Checker for the receive status block, bound to rx_status.
// Assumes the master offers write address and data together.
`timescale 1ns/1ps
module rx_status_properties
	import rx_status_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        clk_fail_report,
	input wire logic        rx_interrupt,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	logic [2:0] ctl_reg;
	wire wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire rd = s_axi_arvalid && s_axi_arready;
	wire ctl_hit = wr && s_axi_awaddr == ADDR_INTCTL && s_axi_wstrb[0];
	wire known = s_axi_araddr inside {ADDR_BUF, ADDR_FMT, ADDR_INTCTL, ADDR_STAT, ADDR_SLOT};
	// Shadow of the enables; it may lead the design by one edge, so checks allow that.
	always_ff @(posedge core_clk)
		if (rst)
			ctl_reg <= '0;
		else if (ctl_hit)
			ctl_reg <= s_axi_wdata[2:0];
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer not held");
	a_rd_answer: assert property (rd |=> s_axi_rvalid)
		else $error("read answer late");
	a_wr_answer: assert property (wr |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	a_unmapped_read: assert property (rd && !known |=>
		s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
		else $error("unmapped read not refused");
	a_slot_range: assert property (rd && s_axi_araddr == ADDR_SLOT |=>
		s_axi_rdata[31:10] == '0 && s_axi_rdata[9:0] <= 10'h17F)
		else $error("slot read out of range");
	a_err_summary: assert property (rd && s_axi_araddr == ADDR_STAT |=>
		s_axi_rdata[8] == |s_axi_rdata[2:0] && s_axi_rdata[31:9] == '0)
		else $error("summary bit wrong");
	a_irq_sticky: assert property ($fell(rx_interrupt) |-> $past(wr) || $past(wr, 2))
		else $error("interrupt fell without a write");
	a_irq_masked: assert property (rx_interrupt |-> ctl_reg != '0 || $past(ctl_reg) != '0)
		else $error("interrupt while all enables clear");
	a_ckf_irq: assert property (clk_fail_report && ctl_reg[2] |=> ##[0:1] rx_interrupt)
		else $error("clock failure did not interrupt");
	c_ckf: cover property (clk_fail_report && ctl_reg[2]);
	c_slot: cover property (rd && s_axi_araddr == ADDR_SLOT);
	c_clear: cover property ($fell(rx_interrupt));
endmodule // rx_status_properties

bind rx_status rx_status_properties chk_u (.core_clk, .rst, .clk_fail_report, .rx_interrupt,
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ==== verif/audio_source.sv ====
// Behavioural audio source driving the receive pins.
// Assumes start is pulsed only while busy is low.
`timescale 1ns/1ps
module audio_source (
	input  wire logic [15:0] n_bits,
	input  wire logic        start,
	output logic             bclk,
	output logic             fs,
	output logic             sd,
	output logic             busy
);
	initial begin
		bclk = 1'b0;
		fs = 1'b0;
		sd = 1'b0;
		busy = 1'b0;
	end
	// The bit clock stands still between frames, as a gated source would.
	always @(posedge start) begin
		busy = 1'b1;
		for (int i = 0; i < n_bits; i++) begin
			fs = (i == 0);
			sd = ~sd;
			#200 bclk = 1'b1;
			#200 bclk = 1'b0;
		end
		fs = 1'b0;
		sd = ~sd;
		busy = 1'b0;
	end
endmodule // audio_source

// ==== verif/rx_status_tb.sv ====
// Bench for rx_status: register bus master, audio source, checks.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/1ps
module rx_status_tb
	import rx_status_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        clk_fail_report = 1'b0;
	logic        start = 1'b0;
	logic [15:0] n_bits = '0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0]  s_axi_wstrb = '0;
	wire         rx_bit_clk_pin, rx_frame_sync_pin, rx_data_pin, busy, rx_interrupt;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	int          num_errors = 0;
	int          samples_checked = 0;

	rx_status dut_u (.core_clk, .rst, .rx_bit_clk_pin, .rx_frame_sync_pin, .rx_data_pin,
		.clk_fail_report, .rx_interrupt, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	audio_source src_u (.n_bits, .start, .bclk(rx_bit_clk_pin), .fs(rx_frame_sync_pin),
		.sd(rx_data_pin), .busy);

	initial forever #25 core_clk = ~core_clk;

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic limit(input logic ok);
		if (!ok) begin
			check("wait", 1'b0, 1'b1);
			test_done();
		end
	endtask
	// Readies are sampled at the falling edge, where they are settled until the handshake edge.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic [1:0] r);
		logic ra, rw, rr, fin;
		@(posedge core_clk);
		if (w) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_wstrb <= 4'hF;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end
		fin = 1'b0;
		for (int n = 0; n < 50 && !fin; n++) begin
			@(negedge core_clk);
			ra = s_axi_awready;
			rw = s_axi_wready;
			rr = s_axi_arready;
			fin = w ? s_axi_bvalid : s_axi_rvalid;
			q = s_axi_rdata;
			r = w ? s_axi_bresp : s_axi_rresp;
			@(posedge core_clk);
			if (ra)
				s_axi_awvalid <= 1'b0;
			if (rw)
				s_axi_wvalid <= 1'b0;
			if (rr)
				s_axi_arvalid <= 1'b0;
			if (fin) begin
				s_axi_bready <= 1'b0;
				s_axi_rready <= 1'b0;
			end
		end
		limit(fin);
	endtask
	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic [1:0] r;
		bus(1'b1, a, d, q, r);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		logic [1:0] r;
		bus(1'b0, a, '0, q, r);
		check($sformatf("reg %h", a), q, e);
	endtask
	task automatic irq(input logic e);
		@(negedge core_clk);
		check("rx_interrupt", rx_interrupt, e);
	endtask
	task automatic frame(input logic [15:0] nb);
		int n;
		@(posedge core_clk);
		n_bits <= nb;
		start <= 1'b1;
		@(posedge core_clk);
		start <= 1'b0;
		for (n = 0; n < 30000 && busy; n++)
			@(posedge core_clk);
		limit(n < 30000);
		// Lets the last bit edge pass the synchroniser and edge detector.
		repeat (8) @(posedge core_clk);
	endtask

	task automatic t_reset();
		logic [31:0] q;
		logic [1:0] r;
		rdc(ADDR_STAT, '0);
		rdc(ADDR_SLOT, '0);
		bus(1'b1, ADDR_SLOT, 32'hFFFFFFFF, q, r);
		check("slot write resp", r, RESP_OKAY);
		rdc(ADDR_SLOT, '0);
		bus(1'b0, 8'h40, '0, q, r);
		check("unmapped resp", r, RESP_SLVERR);
		bus(1'b1, 8'h40, 32'hFFFFFFFF, q, r);
		check("unmapped write resp", r, RESP_SLVERR);
		$display("test reset done");
	endtask
	task automatic t_clkfail();
		wrr(ADDR_INTCTL, 32'h4);
		@(posedge core_clk);
		clk_fail_report <= 1'b1;
		@(posedge core_clk);
		clk_fail_report <= 1'b0;
		irq(1'b1);
		rdc(ADDR_STAT, 32'h104);
		wrr(ADDR_STAT, 32'h0);
		rdc(ADDR_STAT, 32'h104);
		wrr(ADDR_STAT, 32'h4);
		rdc(ADDR_STAT, '0);
		irq(1'b0);
		$display("test clock failure done");
	endtask
	task automatic t_frame();
		wrr(ADDR_FMT, 32'h107);
		wrr(ADDR_INTCTL, 32'h3);
		frame(16'h000C);
		rdc(ADDR_SLOT, 32'h1);
		rdc(ADDR_STAT, 32'h8);
		irq(1'b0);
		frame(16'h000C);
		rdc(ADDR_STAT, 32'h10B);
		rdc(ADDR_BUF, 32'h55);
		rdc(ADDR_SLOT, 32'h1);
		irq(1'b1);
		wrr(ADDR_INTCTL, 32'h0);
		irq(1'b0);
		wrr(ADDR_STAT, 32'h2);
		rdc(ADDR_STAT, 32'h109);
		wrr(ADDR_INTCTL, 32'h1);
		irq(1'b1);
		wrr(ADDR_STAT, 32'h1);
		rdc(ADDR_STAT, 32'h8);
		irq(1'b0);
		$display("test frame done");
	endtask
	task automatic t_long();
		// Sixty-four slots asked for in plain mode: the frame must stop after 32.
		wrr(ADDR_FMT, 32'h00003F07);
		frame(16'h0110);
		rdc(ADDR_SLOT, 32'h1F);
		wrr(ADDR_STAT, 32'h7);
		wrr(ADDR_FMT, 32'h01017F07);
		frame(16'h0C30);
		rdc(ADDR_SLOT, 32'h17F);
		rdc(ADDR_STAT, 32'h109);
		$display("test long frame done");
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_clkfail();
		t_frame();
		t_long();
		test_done();
	end
endmodule // rx_status_tb
